// >>> rtl/mdc_pkg.sv
/*
  Package for the motion-detect configuration block: register offsets,
  field positions, reset values and selector codes.
  Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
*/
package mdc_pkg;

  // ----------------------------------------------------------------
  // Register word indices
  // ----------------------------------------------------------------
  localparam logic [7:0] MDC_OFS_SHADOW_DATA = 8'h13;
  localparam logic [7:0] MDC_OFS_CONFIG = 8'h14;
  localparam logic [7:0] MDC_OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] MDC_OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] MDC_OFS_DELTA_X = 8'h28;
  localparam logic [7:0] MDC_OFS_DELTA_Y = 8'h2C;
  localparam logic [7:0] MDC_OFS_DELTA_Z = 8'h30;
  localparam logic [7:0] MDC_OFS_STATE = 8'h34;

  // Shadow data is printed at 0x13, configuration at 0x14: 0x13 is not a multiple of
  // four, so printed offsets are indices and byte address is index times four.
  localparam logic [9:0] MDC_ADDR_SHADOW_DATA = {MDC_OFS_SHADOW_DATA, 2'b00};
  localparam logic [9:0] MDC_ADDR_CONFIG = {MDC_OFS_CONFIG, 2'b00};
  localparam logic [9:0] MDC_ADDR_IRQ_STATUS = {MDC_OFS_IRQ_STATUS, 2'b00};
  localparam logic [9:0] MDC_ADDR_IRQ_MASK = {MDC_OFS_IRQ_MASK, 2'b00};
  localparam logic [9:0] MDC_ADDR_DELTA_X = {MDC_OFS_DELTA_X, 2'b00};
  localparam logic [9:0] MDC_ADDR_DELTA_Y = {MDC_OFS_DELTA_Y, 2'b00};
  localparam logic [9:0] MDC_ADDR_DELTA_Z = {MDC_OFS_DELTA_Z, 2'b00};
  localparam logic [9:0] MDC_ADDR_STATE = {MDC_OFS_STATE, 2'b00};

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int MDC_SEL_LSB = 0;
  localparam int MDC_CNTEN_BIT = 3;
  localparam int MDC_WIN_LSB = 4;
  localparam int MDC_CLR_BIT = 7;
  localparam logic [7:0] MDC_CONFIG_RESET = 8'h00;
  localparam logic [5:0] MDC_SHADOW_RESET = 6'h00;
  localparam logic [2:0] MDC_IRQ_RESET = 3'h0;

  // Widths and top window code
  localparam int MDC_DELTA_W = 11;
  localparam int MDC_TH_W = 6;
  localparam int MDC_WIN_MAX = 5;

  // ----------------------------------------------------------------
  // Shadow selector codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MDC_SEL_NONE0 = 3'b000,
    MDC_SEL_TH_X = 3'b001,
    MDC_SEL_TH_Y = 3'b010,
    MDC_SEL_TH_Z = 3'b011,
    MDC_SEL_NONE4 = 3'b100,
    MDC_SEL_CNT_X = 3'b101,
    MDC_SEL_CNT_Y = 3'b110,
    MDC_SEL_CNT_Z = 3'b111
  } mdc_sel_t;

  // AHB transfer type and response code
  localparam logic [1:0] MDC_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] MDC_HRESP_OKAY = 2'b00;

endpackage

// >>> rtl/mdc_channel.sv
/*
  One motion-detect channel: window slice with clamp, threshold compare and
  event counter.
  Assumes a one-cycle delta strobe from the sample path on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_channel
  import mdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic block_clear,
  input wire logic count_enable,
  input wire logic [2:0] window_select,
  input wire logic [MDC_TH_W-1:0] threshold,
  input wire logic [MDC_TH_W-1:0] detect_count,
  input wire logic delta_valid,
  input wire logic [MDC_DELTA_W-1:0] delta,
  output logic hit,
  output logic [MDC_TH_W-1:0] event_count
);

  logic [MDC_TH_W-1:0] count_reg;
  logic [MDC_TH_W-1:0] count_next;
  logic hit_reg;
  logic hit_next;
  logic [MDC_TH_W-1:0] slice;
  logic over;

  // ----------------------------------------------------------------
  // Window slice with clamp
  // ----------------------------------------------------------------
  always_comb
  begin
    slice = '0;
    over = 1'b0;
    for (int k = 0; k <= MDC_WIN_MAX; k++)
    begin
      // Codes above 5 share the top window [R3]
      if ((int'(window_select) == k) || (k == MDC_WIN_MAX && int'(window_select) > MDC_WIN_MAX))
      begin
        slice = delta[k +: MDC_TH_W];
        // Bits above the window saturate instead of wrapping [R4]
        over = (k + MDC_TH_W < MDC_DELTA_W) ? |(delta >> (k + MDC_TH_W)) : 1'b0;
      end
    end
    if (over)
    begin
      slice = {MDC_TH_W{1'b1}}; // [R4]
    end
  end

  // ----------------------------------------------------------------
  // Event counter
  // ----------------------------------------------------------------
  always_comb
  begin
    count_next = count_reg;
    hit_next = hit_reg;
    if (block_clear)
    begin
      count_next = '0; // [R5]
      hit_next = 1'b0;
    end
    else if (delta_valid)
    begin
      if (slice > threshold) // [R6]
      begin
        if (!count_enable)
        begin
          hit_next = 1'b1; // Counters unused [R2]
        end
        else if (count_reg >= detect_count)
        begin
          hit_next = 1'b1; // Loaded value is events minus one [R7]
        end
        else
        begin
          count_next = count_reg + 6'h01; // [R2]
        end
      end
      else
      begin
        count_next = '0; // Run broken, restart
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg <= MDC_SHADOW_RESET;
      hit_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      hit_reg <= hit_next;
    end
  end

  assign hit = hit_reg;
  assign event_count = count_reg;

endmodule
`default_nettype wire

// >>> rtl/mdc_top.sv
/*
  Motion-detect configuration register bank with shadow threshold and count
  registers, three detection channels and an interrupt, on AHB-Lite.
  Assumes one master, single whole-word transfers, deltas from on-chip logic.
*/
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) Config bits 2:0 route shadow data accesses to threshold or count.
// (R2) Config bit 3 enables detection counters for all channels.
// (R3) Config bits 6:4 pick delta slice; codes five to seven share top.
// (R4) Slice clamps so oversized delta still counts as detection.
// (R5) Config bit 7 holds detect block in reset; not self-clearing.
// (R6) Thresholds are independent 6-bit unsigned values per axis.
// (R7) Software loads detection count as events minus one.
// (R8) Configuration reads back as written, resets to zero.
module mdc_top
  import mdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic delta_valid,
  input wire logic [MDC_DELTA_W-1:0] delta_x,
  input wire logic [MDC_DELTA_W-1:0] delta_y,
  input wire logic [MDC_DELTA_W-1:0] delta_z,
  output logic irq,
  output logic detect_block_reset,
  output logic count_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [MDC_TH_W-1:0] th_reg [3];
  logic [MDC_TH_W-1:0] th_next [3];
  logic [MDC_TH_W-1:0] cnt_reg [3];
  logic [MDC_TH_W-1:0] cnt_next [3];
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [9:0] wr_addr_reg;
  logic [9:0] wr_addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic [2:0] hit_prev_reg;
  logic [2:0] hit_prev_next;

  logic [2:0] hit;
  logic [MDC_TH_W-1:0] evcnt [3];
  logic [MDC_DELTA_W-1:0] delta [3];
  logic access;
  logic [9:0] a_addr;
  logic [2:0] rise;

  assign delta[0] = delta_x;
  assign delta[1] = delta_y;
  assign delta[2] = delta_z;

  // ----------------------------------------------------------------
  // Shadow decode
  // ----------------------------------------------------------------
  // Returns channel index, or 3 when no shadow is selected
  function automatic logic [1:0] shadow_chan(input logic [2:0] sel);
    logic [1:0] r;
    r = 2'd3;
    unique case (mdc_sel_t'(sel))
      MDC_SEL_TH_X, MDC_SEL_CNT_X: r = 2'd0;
      MDC_SEL_TH_Y, MDC_SEL_CNT_Y: r = 2'd1;
      MDC_SEL_TH_Z, MDC_SEL_CNT_Z: r = 2'd2;
      MDC_SEL_NONE0, MDC_SEL_NONE4: r = 2'd3;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_chan
      mdc_channel u_chan (
        .hclk(hclk),
        .hresetn(hresetn),
        .block_clear(config_reg[MDC_CLR_BIT]),
        .count_enable(config_reg[MDC_CNTEN_BIT]),
        .window_select(config_reg[MDC_WIN_LSB +: 3]),
        .threshold(th_reg[c]),
        .detect_count(cnt_reg[c]),
        .delta_valid(delta_valid),
        .delta(delta[c]),
        .hit(hit[c]),
        .event_count(evcnt[c])
      );
    end
  endgenerate

  assign access = hsel && hready && (htrans == MDC_HTRANS_NONSEQ);
  assign a_addr = haddr[9:0];
  assign rise = hit & ~hit_prev_reg;

  // ----------------------------------------------------------------
  // Bus and register next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [1:0] ch;
    logic [1:0] wch;
    ch = shadow_chan(config_reg[MDC_SEL_LSB +: 3]);
    wch = ch;
    config_next = config_reg;
    th_next = th_reg;
    cnt_next = cnt_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rdata_next = '0;
    wr_pend_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    hit_prev_next = hit;

    // Write data phase
    if (wr_pend_reg)
    begin
      unique case (wr_addr_reg)
        MDC_ADDR_CONFIG: config_next = hwdata[7:0]; // [R8]
        MDC_ADDR_SHADOW_DATA:
        begin
          if (wch != 2'd3)
          begin
            if (config_reg[2]) // [R1]
            begin
              cnt_next[wch] = hwdata[MDC_TH_W-1:0]; // [R7]
            end
            else
            begin
              th_next[wch] = hwdata[MDC_TH_W-1:0]; // [R6]
            end
          end
        end
        MDC_ADDR_IRQ_MASK: mask_next = hwdata[2:0];
        default: ;
      endcase
    end

    // Address phase
    if (access)
    begin
      if (hwrite)
      begin
        wr_pend_next = 1'b1;
        wr_addr_next = a_addr;
      end
      else
      begin
        unique case (a_addr)
          MDC_ADDR_CONFIG: rdata_next = {24'h000000, config_reg}; // [R8]
          MDC_ADDR_SHADOW_DATA:
          begin
            if (ch != 2'd3)
            begin
              // [R1]
              rdata_next = {26'h0000000, config_reg[2] ? cnt_reg[ch] : th_reg[ch]};
            end
          end
          MDC_ADDR_IRQ_STATUS:
          begin
            rdata_next = {29'h00000000, status_reg};
            status_next = 3'h0; // Read clears
          end
          MDC_ADDR_IRQ_MASK: rdata_next = {29'h00000000, mask_reg};
          MDC_ADDR_DELTA_X: rdata_next = {26'h0000000, evcnt[0]};
          MDC_ADDR_DELTA_Y: rdata_next = {26'h0000000, evcnt[1]};
          MDC_ADDR_DELTA_Z: rdata_next = {26'h0000000, evcnt[2]};
          MDC_ADDR_STATE: rdata_next = {29'h00000000, hit};
          default: rdata_next = '0;
        endcase
      end
    end

    // New detections win over a read clear
    status_next = status_next | rise;
    irq_next = |(status_next & mask_reg);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_reg <= MDC_CONFIG_RESET; // [R8]
      for (int i = 0; i < 3; i++)
      begin
        th_reg[i] <= MDC_SHADOW_RESET;
        cnt_reg[i] <= MDC_SHADOW_RESET;
      end
      status_reg <= MDC_IRQ_RESET;
      mask_reg <= MDC_IRQ_RESET;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rdata_reg <= '0;
      irq_reg <= 1'b0;
      hit_prev_reg <= 3'h0;
    end
    else
    begin
      config_reg <= config_next;
      th_reg <= th_next;
      cnt_reg <= cnt_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      hit_prev_reg <= hit_prev_next;
    end
  end

  // Zero wait states; response is always OKAY
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = MDC_HRESP_OKAY[0];
  assign irq = irq_reg;
  assign detect_block_reset = config_reg[MDC_CLR_BIT]; // [R5]
  assign count_enable = config_reg[MDC_CNTEN_BIT]; // [R2]

endmodule
`default_nettype wire

// >>> sim/mdc_chk.sv
/* Port checker for mdc_top.
   Assumes hready looped from hreadyout and a single bus master. */
`timescale 1ns/1ps
`default_nettype none
module mdc_chk
  import mdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic delta_valid,
  input wire logic [MDC_DELTA_W-1:0] delta_x,
  input wire logic irq,
  input wire logic detect_block_reset,
  input wire logic count_enable
);
  // ------
  // Register shadow model
  // ------
  logic wr_q, rd_q, mk_m;
  // Hit latches until block clear; compares only count while armed
  logic armed_m;
  logic [9:0] a_q;
  logic [7:0] cfg_m;
  logic [5:0] sh_m [8];
  logic [2:0] lsb;
  logic [10:0] sft;
  logic [5:0] slc;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      mk_m <= 1'h0;
      armed_m <= 1'h1;
      a_q <= 10'h000;
      cfg_m <= MDC_CONFIG_RESET;
      for (int i = 0; i < 8; i++) sh_m[i] <= MDC_SHADOW_RESET;
    end
    else
    begin
      wr_q <= hsel && htrans == MDC_HTRANS_NONSEQ && hwrite;
      rd_q <= hsel && htrans == MDC_HTRANS_NONSEQ && !hwrite;
      a_q <= haddr[9:0];
      if (wr_q && a_q == MDC_ADDR_CONFIG) cfg_m <= hwdata[7:0];
      if (wr_q && a_q == MDC_ADDR_SHADOW_DATA) sh_m[cfg_m[2:0]] <= hwdata[5:0];
      if (wr_q && a_q == MDC_ADDR_IRQ_MASK) mk_m <= hwdata[0];
      if (detect_block_reset) armed_m <= 1'h1;
      else if (delta_valid && (count_enable || slc > sh_m[1])) armed_m <= 1'h0;
    end
  end
  // Saturating slice, so upper delta bits never wrap to a small value
  assign lsb = (cfg_m[6:4] > 3'h5) ? 3'h5 : cfg_m[6:4];
  assign sft = delta_x >> lsb;
  assign slc = (sft > 11'h03F) ? 6'h3F : sft[5:0];
  // ------
  // Properties
  // ------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(a);
    rd_q && a_q == a;
  endsequence
  sequence s_arm;
    delta_valid && !count_enable && !detect_block_reset && !irq && mk_m && armed_m;
  endsequence
  a_reset_zero:
    assert property ($rose(hresetn) |-> !detect_block_reset && !count_enable) else $error("outputs not clear after reset");
  a_cnten_tracks:
    assert property ($changed(count_enable) |-> count_enable == cfg_m[3]) else $error("count enable off config");
  a_clear_tracks:
    assert property ($changed(detect_block_reset) |-> detect_block_reset == cfg_m[7]) else $error("clear off config");
  a_clear_holds:
    assert property (detect_block_reset && cfg_m[7] |=> detect_block_reset || !cfg_m[7]) else $error("clear dropped");
  a_cfg_read:
    assert property (s_rd(MDC_ADDR_CONFIG) |-> hrdata == {24'h0, cfg_m}) else $error("config readback");
  a_shadow_read:
    assert property (s_rd(MDC_ADDR_SHADOW_DATA) |-> hrdata == ((cfg_m[1:0] == 2'h0) ? 32'h0
      : {26'h0, sh_m[cfg_m[2:0]]})) else $error("shadow readback");
  a_hit_irq:
    assert property (s_arm and slc > sh_m[1] |-> ##[2:4] irq) else $error("exceeding delta missed");
  a_miss_quiet:
    assert property (s_arm and slc <= sh_m[1] |=> !irq [*3]) else $error("small delta raised irq");
  a_clear_blocks:
    assert property ($rose(irq) |-> !$past(detect_block_reset, 2)) else $error("event while held clear");
endmodule
`default_nettype wire

// >>> sim/mdc_top_tb.sv
/* Bench for mdc_top: AHB-Lite register access, deltas and irq.
   Assumes hready looped from hreadyout; delta_y and delta_z idle at zero except in t_axes. */
`timescale 1ns/1ps
`default_nettype none
module mdc_top_tb
  import mdc_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic delta_valid = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd_q;
  logic [MDC_DELTA_W-1:0] delta_x = 11'h000;
  logic [MDC_DELTA_W-1:0] delta_y = 11'h000;
  logic [MDC_DELTA_W-1:0] delta_z = 11'h000;
  logic hreadyout, hresp, irq, detect_block_reset, count_enable;
  int n_errors = 0;
  int checks_done = 0;
  always #5 hclk = ~hclk;
  // Edge copy of read data avoids racing the slave's own update
  always @(posedge hclk) rd_q <= hrdata;
  mdc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .delta_valid(delta_valid), .delta_x(delta_x), .delta_y(delta_y), .delta_z(delta_z), .irq(irq),
    .detect_block_reset(detect_block_reset), .count_enable(count_enable));
  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic [9:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {22'h0, a};
    hwrite <= w;
    htrans <= MDC_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    #1 r = rd_q;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'h1, d, r);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'h0, 32'h0, r);
    chk(r, e);
  endtask
  // Hits latch until block clear, so every fresh detection needs a re-arm
  task automatic rearm(input logic [31:0] c);
    wr(MDC_ADDR_CONFIG, c | 32'h80);
    wr(MDC_ADDR_CONFIG, c);
  endtask
  task automatic pulse(input logic [10:0] v);
    @(posedge hclk);
    delta_valid <= 1'h1;
    delta_x <= v;
    @(posedge hclk);
    delta_valid <= 1'h0;
    repeat (4) @(posedge hclk);
    #1;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_cfg;
    rd(MDC_ADDR_CONFIG, 32'h0);
    chk({30'h0, detect_block_reset, count_enable}, 32'h0);
    rd(10'h3FC, 32'h0);
    wr(MDC_ADDR_CONFIG, 32'hFF);
    repeat (3) @(posedge hclk);
    #1 chk({30'h0, detect_block_reset, count_enable}, 32'h3);
    rd(MDC_ADDR_CONFIG, 32'hFF);
    wr(MDC_ADDR_CONFIG, 32'h5A);
    rd(MDC_ADDR_CONFIG, 32'h5A);
  endtask
  task automatic t_shadow;
    for (int s = 0; s < 8; s++)
    begin
      wr(MDC_ADDR_CONFIG, 32'(s));
      wr(MDC_ADDR_SHADOW_DATA, 32'hFFFFFF38 + 32'(s));
    end
    for (int s = 0; s < 8; s++)
    begin
      wr(MDC_ADDR_CONFIG, 32'(s));
      rd(MDC_ADDR_SHADOW_DATA, (s % 4 == 0) ? 32'h0 : 32'h38 + 32'(s));
    end
  endtask
  task automatic t_window;
    int l;
    wr(MDC_ADDR_IRQ_MASK, 32'h7);
    wr(MDC_ADDR_CONFIG, 32'h1);
    wr(MDC_ADDR_SHADOW_DATA, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      l = (c > 5) ? 5 : c;
      rearm(32'h1 | 32'(c << 4));
      pulse(11'((1 << l) - 1));
      chk({31'h0, irq}, 32'h0);
      pulse(11'(1 << l));
      chk({31'h0, irq}, 32'h1);
      rd(MDC_ADDR_IRQ_STATUS, 32'h1);
      pulse(11'h000);
      chk({31'h0, irq}, 32'h0);
      rd(MDC_ADDR_IRQ_STATUS, 32'h0);
    end
  endtask
  task automatic t_clamp;
    rearm(32'h1);
    wr(MDC_ADDR_SHADOW_DATA, 32'h3E);
    pulse(11'h400);
    rd(MDC_ADDR_IRQ_STATUS, 32'h1);
    rearm(32'h1);
    pulse(11'h03E);
    rd(MDC_ADDR_IRQ_STATUS, 32'h0);
    wr(MDC_ADDR_SHADOW_DATA, 32'h0);
  endtask
  task automatic t_count;
    wr(MDC_ADDR_IRQ_MASK, 32'h0);
    rearm(32'hD);
    wr(MDC_ADDR_SHADOW_DATA, 32'h2);
    pulse(11'h001);
    pulse(11'h001);
    rd(MDC_ADDR_IRQ_STATUS, 32'h0);
    pulse(11'h001);
    chk({31'h0, irq}, 32'h0);
    rd(MDC_ADDR_IRQ_STATUS, 32'h1);
    pulse(11'h000);
    wr(MDC_ADDR_IRQ_MASK, 32'h7);
  endtask
  task automatic t_clear;
    wr(MDC_ADDR_CONFIG, 32'h81);
    pulse(11'h7FF);
    rd(MDC_ADDR_IRQ_STATUS, 32'h0);
    chk({31'h0, detect_block_reset}, 32'h1);
    wr(MDC_ADDR_CONFIG, 32'h1);
    pulse(11'h7FF);
    rd(MDC_ADDR_IRQ_STATUS, 32'h1);
  endtask
  // Y threshold 0x3A and Z threshold 0x3B remain from the shadow scenario
  task automatic t_axes;
    wr(MDC_ADDR_IRQ_MASK, 32'h1);
    rearm(32'h2);
    @(posedge hclk);
    delta_y <= 11'h03B;
    delta_z <= 11'h03B;
    pulse(11'h000);
    chk({31'h0, irq}, 32'h0);
    rd(MDC_ADDR_IRQ_STATUS, 32'h2);
    chk({31'h0, hresp}, {31'h0, MDC_HRESP_OKAY[0]});
    @(posedge hclk);
    delta_y <= 11'h000;
    delta_z <= 11'h000;
  endtask
  task automatic wrap_up;
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    t_cfg();
    t_shadow();
    t_window();
    t_clamp();
    t_count();
    t_clear();
    t_axes();
    wrap_up();
  end
  // Run needs about five hundred cycles; far beyond that is a hang
  initial
  begin
    #200000;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
bind mdc_top mdc_chk chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .delta_valid(delta_valid), .delta_x(delta_x), .irq(irq),
  .detect_block_reset(detect_block_reset), .count_enable(count_enable));
`default_nettype wire
